/* gpio_consts.vh */
// register offsets, field positions and reset values for the six-pin port
// included by the port top and its pin-sync leaf
`ifndef GPIO_CONSTS_VH
`define GPIO_CONSTS_VH
`define OFS_PIN_LEVEL 4'h0
`define OFS_DIRECTION 4'h4
`define OFS_OUTPUT_LATCH 4'h8
`define OFS_ANALOG_SELECT 4'hc
`define OFS_STEERING 5'h10
`define OFS_PERIPH_ENABLE 5'h14
`define NUM_PINS 6
`define INPUT_ONLY_PIN 3
`define DIRECTION_RESET 6'h3f
`define ANALOG_RESET 6'h37
`define LATCH_RESET 6'h00
`define STEERING_RESET 8'h00
`define STEERING_MASK 8'h70
`define BIT_SERIAL_OUT_SEL 6
`define BIT_SLAVE_SEL_SEL 5
`define BIT_SERIAL_IN_SEL 4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* pin_sync.v */
// two-stage synchroniser for the raw pin levels
// assumes pins are asynchronous to aclk; first stage feeds only the second
`timescale 1ns/100ps
`include "gpio_consts.vh"
module pin_sync #(
   parameter WIDTH = `NUM_PINS
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         stage1_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else if (ce) begin
         stage1_reg <= async_in;
         sync_out <= stage1_reg;
      end
   end
endmodule // pin_sync

/* gpio_port.v */
// six-pin general-purpose port with alternate pin steering, AXI4-Lite slave
// assumes pads resolve out/oe_n externally and the serial unit runs on aclk
//
// Notes on behaviour
// - latch write equals pin-level register write
// - latch reads latches; pin-level reads pins
// - analog select disables digital input buffer
// - peripheral owns pin output; pin stays readable
// - serial-out on pin 4 if set, else 0
// - slave-select from pin 0 if set, else 3
// - serial-in/data on pin 3 if set, else 2
// - steering keeps direction bits; overrides follow function
// - serial unit may pull pin 3 low
// - six pins, five bidirectional, each with direction
// - direction 1 input, 0 drives latch
// - pin 3 input-only, direction reads 1
// - pin-level write overwrites latch directly, no read-modify-write
// - direction still controls drivers in analog mode
// - analog pins read digital zero
// - analog select never affects digital output
// - analog bits reset to analog; software clears
// - highest-priority enabled output function owns pin
`timescale 1ns/100ps
`include "gpio_consts.vh"
module gpio_port #(
   parameter N = `NUM_PINS
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [N-1:0] pin_in,
   output wire [N-1:0] pin_out,
   output wire [N-1:0] pin_oe_n,
   output wire [N-1:0] digital_in_enable,
   input wire serial_out_data,
   input wire serial_out_enable,
   output wire serial_out_active_pin4,
   output wire slave_select_n,
   input wire serial_data_pull_low,
   output wire serial_data_in,
   input wire serial_clock_data,
   input wire serial_clock_enable
);
   reg [N-1:0] port_output_latch;
   reg [N-1:0] port_direction;
   reg [N-1:0] port_analog_select;
   reg [7:0] alternate_pin_steering;
   reg [1:0] periph_enable_reg;
   reg [31:0] aw_addr_reg;
   reg aw_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg w_held_reg;
   wire [N-1:0] pin_sync_level;
   wire [N-1:0] port_pin_level;
   wire serial_out_pin_select;
   wire slave_select_pin_select;
   wire serial_in_pin_select;
   wire [N-1:0] periph_drive;
   wire [N-1:0] periph_value;
   wire [N-1:0] periph_owns;
   wire [N-1:0] dir_eff;
   wire do_write;
   wire [N-1:0] wr_bits;
   wire wr_lane0;
   wire [4:0] wr_ofs;
   wire [4:0] rd_ofs;

   pin_sync #(.WIDTH(N)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .async_in(pin_in),
      .sync_out(pin_sync_level)
   );

   assign serial_out_pin_select = alternate_pin_steering[`BIT_SERIAL_OUT_SEL];
   assign slave_select_pin_select = alternate_pin_steering[`BIT_SLAVE_SEL_SEL];
   assign serial_in_pin_select = alternate_pin_steering[`BIT_SERIAL_IN_SEL];

   // digital input buffer gated off on analog pins, so they read zero
   assign digital_in_enable = ~port_analog_select;
   assign port_pin_level = pin_sync_level & ~port_analog_select;

   // peripheral input routing, taken from synchronised levels
   assign slave_select_n = slave_select_pin_select ? port_pin_level[0] : port_pin_level[3];
   assign serial_data_in = serial_in_pin_select ? port_pin_level[3] : port_pin_level[2];

   // override per pin; only the selected pin gets it, the other is untouched
   // periph_enable_reg[0] = serial-out enable, [1] = two-wire data enable
   wire so_on;
   wire sd_on;
   assign so_on = periph_enable_reg[0] & serial_out_enable;
   assign sd_on = periph_enable_reg[1] & serial_data_pull_low;
   assign serial_out_active_pin4 = serial_out_pin_select;
   assign periph_drive[0] = so_on & ~serial_out_pin_select;
   assign periph_drive[1] = serial_clock_enable;
   assign periph_drive[2] = sd_on & ~serial_in_pin_select;
   assign periph_drive[3] = sd_on & serial_in_pin_select;
   assign periph_drive[4] = so_on & serial_out_pin_select;
   assign periph_drive[5] = 1'b0;
   assign periph_value[0] = serial_out_data;
   assign periph_value[1] = serial_clock_data;
   assign periph_value[2] = 1'b0;
   assign periph_value[3] = 1'b0;
   assign periph_value[4] = serial_out_data;
   assign periph_value[5] = 1'b0;
   assign periph_owns = periph_drive;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi = gi + 1) begin : g_pin
         if (gi == `INPUT_ONLY_PIN) begin : g_in_only
            assign dir_eff[gi] = 1'b1;
         end else begin : g_bidir
            assign dir_eff[gi] = port_direction[gi];
         end
         // enabled peripheral wins over port latch; analog select not involved
         assign pin_out[gi] = periph_owns[gi] ? periph_value[gi] : port_output_latch[gi];
         assign pin_oe_n[gi] = periph_owns[gi] ? 1'b0 : dir_eff[gi];
      end
   endgenerate

   // write channel: address and data taken independently, response after both
   assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
   assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid & ce;
   assign wr_ofs = aw_addr_reg[4:0];
   assign wr_lane0 = w_strb_reg[0];
   // no rmw: every latch bit takes written data; pin 3 masked at the write
   assign wr_bits = w_data_reg[N-1:0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 32'h00000000;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         port_output_latch <= `LATCH_RESET;
         port_direction <= `DIRECTION_RESET;
         port_analog_select <= `ANALOG_RESET;
         alternate_pin_steering <= `STEERING_RESET;
         periph_enable_reg <= 2'b00;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_held_reg <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_held_reg <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            if (aw_addr_reg[31:5] != 27'h0000000) begin
               s_axi_bresp <= `RESP_SLVERR;
            end else if (wr_ofs == {1'b0, `OFS_PIN_LEVEL} || wr_ofs == {1'b0, `OFS_OUTPUT_LATCH}) begin
               // both addresses land in the latch; pin 3 bit has no latch
               if (wr_lane0) begin
                  port_output_latch <= wr_bits & 6'h37;
               end
            end else if (wr_ofs == {1'b0, `OFS_DIRECTION}) begin
               if (wr_lane0) begin
                  port_direction <= wr_bits | 6'h08;
               end
            end else if (wr_ofs == {1'b0, `OFS_ANALOG_SELECT}) begin
               if (wr_lane0) begin
                  port_analog_select <= wr_bits & 6'h37;
               end
            end else if (wr_ofs == `OFS_STEERING) begin
               if (wr_lane0) begin
                  alternate_pin_steering <= w_data_reg[7:0] & `STEERING_MASK;
               end
            end else if (wr_ofs == `OFS_PERIPH_ENABLE) begin
               if (wr_lane0) begin
                  periph_enable_reg <= w_data_reg[1:0];
               end
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end
      end
   end

   // read channel: one read at a time, answer one cycle after address taken
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_ofs = s_axi_araddr[4:0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr[31:5] != 27'h0000000) begin
               s_axi_rresp <= `RESP_SLVERR;
            end else if (rd_ofs == {1'b0, `OFS_PIN_LEVEL}) begin
               // pin level stays readable even under peripheral control
               s_axi_rdata <= {26'h0000000, port_pin_level};
            end else if (rd_ofs == {1'b0, `OFS_OUTPUT_LATCH}) begin
               s_axi_rdata <= {26'h0000000, port_output_latch};
            end else if (rd_ofs == {1'b0, `OFS_DIRECTION}) begin
               s_axi_rdata <= {26'h0000000, dir_eff};
            end else if (rd_ofs == {1'b0, `OFS_ANALOG_SELECT}) begin
               s_axi_rdata <= {26'h0000000, port_analog_select};
            end else if (rd_ofs == `OFS_STEERING) begin
               s_axi_rdata <= {24'h000000, alternate_pin_steering};
            end else if (rd_ofs == `OFS_PERIPH_ENABLE) begin
               s_axi_rdata <= {30'h00000000, periph_enable_reg};
            end else begin
               s_axi_rresp <= `RESP_SLVERR;
            end
         end
      end
   end
endmodule // gpio_port

/* gpio_port_sva.sv */
// checker: bus handshakes, pin 3 drive limits and reset state at the port's pins
// assumes ce is only ever low while the bus is idle
`timescale 1ns/100ps
module gpio_port_sva (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [5:0] pin_out,
   input wire [5:0] pin_oe_n,
   input wire [5:0] digital_in_enable,
   input wire serial_data_pull_low
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_b_late; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
   property p_wr_resp; s_wr |=> s_b_late; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer mistimed");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_r_release; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_release: assert property (p_r_release) else $error("read answer not released");
   // pin 3 has no high driver: any drive on it must be a low
   property p_pin3_low; !pin_oe_n[3] |-> !pin_out[3]; endproperty
   a_pin3_low: assert property (p_pin3_low) else $error("pin 3 driven high");
   property p_pin3_in; !serial_data_pull_low |-> pin_oe_n[3]; endproperty
   a_pin3_in: assert property (p_pin3_in) else $error("pin 3 driven");
   property p_rst; $rose(aresetn) |-> digital_in_enable == 6'h08 && pin_oe_n == 6'h3f; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
endmodule // gpio_port_sva
bind gpio_port gpio_port_sva gpio_port_sva_inst (.*);

/* pin_board.sv */
// board side of the six pads
// assumes no pull-ups; an undriven pad follows the outside level set by the bench
`timescale 1ns/100ps
module pin_board (
   input wire [5:0] pin_out,
   input wire [5:0] pin_oe_n,
   input wire [5:0] ext_level,
   output wire [5:0] pin_in
);
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // pin_board

/* gpio_port_bench.sv */
// self-checking bench for the six-pin port, register model kept in plain variables
// assumes ce drops only while the bus is idle; pads resolved by pin_board
`timescale 1ns/100ps
module gpio_port_bench;
   reg aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, serial_out_data = 1'b0;
   reg serial_out_enable = 1'b0, serial_data_pull_low = 1'b0;
   reg serial_clock_data = 1'b0, serial_clock_enable = 1'b0;
   reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg [5:0] ext_level = 6'h00, m_dir = 6'h3f, m_lat = 6'h00, m_ana = 6'h37;
   reg [31:0] seed = 32'h00014163, d;
   reg da, dw;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire serial_out_active_pin4, slave_select_n, serial_data_in;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [5:0] pin_in, pin_out, pin_oe_n, digital_in_enable;
   integer n_errors = 0, check_count = 0, cyc = 0, i;
   gpio_port gpio_port_inst (.*);
   pin_board pin_board_inst (.*);
   initial forever #25 aclk = ~aclk;
   function [31:0] xs;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         xs = seed;
      end
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d errors %0d", check_count, n_errors);
         if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // ready is sampled at the negedge before the edge that takes it
   task wr(input [31:0] a, input [31:0] v, input [1:0] er);
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         da = 1'b0;
         dw = 1'b0;
         while (!(da && dw)) begin
            @(negedge aclk);
            if (s_axi_awready) da = 1'b1;
            if (s_axi_wready) dw = 1'b1;
            @(posedge aclk);
            if (da) s_axi_awvalid <= 1'b0;
            if (dw) s_axi_wvalid <= 1'b0;
         end
         do @(negedge aclk); while (!s_axi_bvalid);
         @(posedge aclk);
         s_axi_bready <= 1'b1;
         @(negedge aclk);
         chk(s_axi_bresp, er);
         @(posedge aclk);
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [31:0] a, input [31:0] e, input [1:0] er);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do @(negedge aclk); while (!s_axi_arready);
         @(posedge aclk);
         s_axi_arvalid <= 1'b0;
         do @(negedge aclk); while (!s_axi_rvalid);
         @(posedge aclk);
         s_axi_rready <= 1'b1;
         @(negedge aclk);
         chk(s_axi_rresp, er);
         if (er == 2'b00) chk(s_axi_rdata, e);
         @(posedge aclk);
         s_axi_rready <= 1'b0;
      end
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         conclude;
      end
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk(digital_in_enable, 6'h08);
      rd(32'h4, 32'h3f, 2'b00);
      rd(32'hc, 32'h37, 2'b00);
      rd(32'h10, 32'h0, 2'b00);
      rd(32'h18, 32'h0, 2'b10);
      wr(32'h18, 32'h3f, 2'b10);
      wr(32'hc, 32'h0, 2'b00);
      m_ana = 6'h00;
      for (i = 0; i < 8; i = i + 1) begin
         d = xs();
         ext_level <= d[5:0];
         d = xs();
         wr(32'h4, d, 2'b00);
         m_dir = d[5:0] | 6'h08;
         d = xs();
         wr({28'h0, i[0], 3'h0}, d, 2'b00);
         m_lat = d[5:0] & 6'h37;
         d = xs();
         if (i > 3) begin
            wr(32'hc, d, 2'b00);
            m_ana = d[5:0] & 6'h37;
         end
         repeat (3) @(posedge aclk);
         chk(pin_oe_n, m_dir);
         chk(pin_out & ~m_dir, m_lat & ~m_dir);
         chk(digital_in_enable, ~m_ana & 6'h3f);
         rd(32'h8, m_lat, 2'b00);
         rd(32'h0, {26'h0, ((ext_level & m_dir) | (m_lat & ~m_dir)) & ~m_ana}, 2'b00);
      end
      wr(32'hc, 32'h0, 2'b00);
      wr(32'h10, 32'hff, 2'b00);
      rd(32'h10, 32'h70, 2'b00);
      rd(32'h4, {26'h0, m_dir}, 2'b00);
      wr(32'h14, 32'h3, 2'b00);
      rd(32'h14, 32'h3, 2'b00);
      d = xs();
      ext_level <= d[5:0];
      serial_out_data <= d[6];
      serial_out_enable <= 1'b1;
      repeat (3) @(posedge aclk);
      serial_data_pull_low <= 1'b1;
      @(negedge aclk);
      chk(serial_out_active_pin4, 1'b1);
      chk(serial_data_in, ext_level[3]);
      chk(slave_select_n, m_dir[0] ? ext_level[0] : m_lat[0]);
      chk({pin_oe_n[3], pin_out[3]}, 2'b00);
      chk({pin_oe_n[4], pin_out[4]}, {1'b0, serial_out_data});
      chk(pin_oe_n[0], m_dir[0]);
      wr(32'h10, 32'h0, 2'b00);
      chk(pin_oe_n[3], 1'b1);
      chk({pin_oe_n[2], pin_out[2]}, 2'b00);
      chk({pin_oe_n[0], pin_out[0]}, {1'b0, serial_out_data});
      chk(pin_oe_n[4], m_dir[4]);
      @(posedge aclk);
      serial_data_pull_low <= 1'b0;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk(serial_out_active_pin4, 1'b0);
      chk(serial_data_in, m_dir[2] ? ext_level[2] : m_lat[2]);
      chk(slave_select_n, ext_level[3]);
      // with ce low the synchroniser must hold its old level
      @(posedge aclk);
      ce <= 1'b0;
      ext_level <= ext_level ^ 6'h08;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      chk(slave_select_n, !ext_level[3]);
      @(posedge aclk);
      ce <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk(slave_select_n, ext_level[3]);
      @(posedge aclk);
      serial_out_enable <= 1'b0;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(32'h4, 32'h3f, 2'b00);
      rd(32'hc, 32'h37, 2'b00);
      rd(32'h14, 32'h0, 2'b00);
      conclude;
   end
endmodule // gpio_port_bench
